// [design/sssw_pkg.sv]
// Purpose: Constants for the spindle status word three block
// Assumes: 16-bit status word, plain register port
// Notes:   Bit positions and selection codes of the status word
package sssw_pkg;
    localparam int          WORD_W         = 16;
    localparam int          SEL_W          = 5;
    localparam int          NUM_GPO        = 14;
    localparam int          ADDR_W         = 4;
    // Register indices
    localparam logic [3:0]  ADDR_STATUS    = 4'h0;
    localparam logic [3:0]  ADDR_SEL_FIRST = 4'h1;
    // Status word bit positions
    localparam int          BIT_MODE1      = 0;
    localparam int          BIT_GEAR1      = 5;
    localparam int          BIT_GEAR2      = 6;
    localparam int          BIT_FWD_ROT    = 8;
    localparam int          BIT_REV_ROT    = 9;
    localparam int          BIT_FWD_IDX    = 10;
    localparam int          BIT_REV_IDX    = 11;
    localparam int          BIT_ORIENT     = 12;
    localparam int          BIT_LOW_WIND   = 13;
    localparam int          BIT_SUB_MOTOR  = 14;
    // Output selection codes and status word reset value
    localparam logic [4:0]  SEL_RESET      = 5'h00;
    localparam logic [4:0]  SEL_MAX        = 5'h17;
    localparam logic [4:0]  SEL_FWD_ROT    = 5'h07;
    localparam logic [4:0]  SEL_REV_ROT    = 5'h08;
    localparam logic [4:0]  SEL_LOW_WIND   = 5'h12;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
endpackage

// [design/sssw_status_word.sv]
// Purpose: Assembles status word three and drives general-purpose outputs
// Assumes: Command inputs synchronous to clk_i
// Notes:   Status word registered one cycle behind inputs, outputs two cycles behind
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1: Bits 0 to 4 follow control-mode select commands 1 to 5.
// RQ2: Bits 5 and 6 follow gear select commands 1 and 2.
// RQ3: Bit 8 set only when started and turning counter-clockwise.
// RQ4: Bit 9 set only when started and turning clockwise.
// RQ5: Reader tolerates direction flags toggling at very low speed.
// RQ6: Bits A and B follow forward and reverse indexing commands.
// RQ7: Bit C follows the orientation start command.
// RQ8: Bit D follows the low-speed winding select input.
// RQ9: Bit E follows sub-motor selection in two-motor setups.
// RQ10: Output selection code 7 drives output from forward-rotation flag.
// RQ11: Output selection code 8 drives output from reverse-rotation flag.
// RQ12: Output selection code 18 drives output from low-winding flag.
// RQ13: Bits 7 and F always read as zero.
module sssw_status_word (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    // Command inputs
    input  wire logic [4:0]                mode_select_i,
    input  wire logic [1:0]                gear_select_i,
    input  wire logic                      start_command_i,
    input  wire logic                      rotating_ccw_i,
    input  wire logic                      rotating_cw_i,
    input  wire logic                      forward_index_command_i,
    input  wire logic                      reverse_index_command_i,
    input  wire logic                      orient_start_command_i,
    input  wire logic                      low_winding_select_input_i,
    input  wire logic                      sub_motor_select_i,
    // Register port
    input  wire logic [3:0]                reg_addr_i,
    input  wire logic [15:0]               reg_wdata_i,
    input  wire logic                      reg_write_i,
    input  wire logic                      reg_read_i,
    output logic      [15:0]               reg_rdata_o,
    // Status and general-purpose outputs
    output logic      [15:0]               spindle_command_echo_status_o,
    output logic      [13:0]               gpo_o
);

    logic [15:0] status_next;
    logic [15:0] status_reg;
    logic [4:0]  sel_reg [14];
    logic [13:0] gpo_next;
    logic [13:0] gpo_reg;
    logic [15:0] rdata_reg;

    // Map a selection code onto the flag it routes
    function automatic logic route_sel(input logic [4:0] code, input logic [15:0] word);
        case (code)
            sssw_pkg::SEL_FWD_ROT:  route_sel = word[sssw_pkg::BIT_FWD_ROT];  // RQ10
            sssw_pkg::SEL_REV_ROT:  route_sel = word[sssw_pkg::BIT_REV_ROT];  // RQ11
            sssw_pkg::SEL_LOW_WIND: route_sel = word[sssw_pkg::BIT_LOW_WIND]; // RQ12
            // Other codes belong to other status words
            default:                route_sel = 1'b0;
        endcase
    endfunction

    always_comb begin
        status_next = sssw_pkg::STATUS_RESET; // RQ13
        status_next[sssw_pkg::BIT_MODE1 +: 5] = mode_select_i; // RQ1
        status_next[sssw_pkg::BIT_GEAR1] = gear_select_i[0]; // RQ2
        status_next[sssw_pkg::BIT_GEAR2] = gear_select_i[1]; // RQ2
        // Both directions at once cannot be real; report neither
        status_next[sssw_pkg::BIT_FWD_ROT] = start_command_i & rotating_ccw_i
                                             & ~rotating_cw_i; // RQ3
        status_next[sssw_pkg::BIT_REV_ROT] = start_command_i & rotating_cw_i
                                             & ~rotating_ccw_i; // RQ4
        status_next[sssw_pkg::BIT_FWD_IDX] = forward_index_command_i; // RQ6
        status_next[sssw_pkg::BIT_REV_IDX] = reverse_index_command_i; // RQ6
        status_next[sssw_pkg::BIT_ORIENT] = orient_start_command_i; // RQ7
        status_next[sssw_pkg::BIT_LOW_WIND] = low_winding_select_input_i; // RQ8
        status_next[sssw_pkg::BIT_SUB_MOTOR] = sub_motor_select_i; // RQ9
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_reg <= sssw_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Selection registers; out-of-range codes are refused and keep the old value
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < sssw_pkg::NUM_GPO; i++) begin
                sel_reg[i] <= sssw_pkg::SEL_RESET;
            end
        end else begin
            for (int i = 0; i < sssw_pkg::NUM_GPO; i++) begin
                if (reg_write_i && reg_addr_i == sssw_pkg::ADDR_SEL_FIRST + 4'(i)
                    && reg_wdata_i[4:0] <= sssw_pkg::SEL_MAX && reg_wdata_i[15:5] == 11'h000) begin
                    sel_reg[i] <= reg_wdata_i[4:0];
                end
            end
        end
    end

    // Route from the registered word so outputs match what is reported
    always_comb begin
        for (int i = 0; i < sssw_pkg::NUM_GPO; i++) begin
            gpo_next[i] = route_sel(sel_reg[i], status_reg);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gpo_reg <= 14'h0000;
        end else begin
            gpo_reg <= gpo_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 16'h0000;
        end else if (reg_read_i) begin
            if (reg_addr_i == sssw_pkg::ADDR_STATUS) begin
                rdata_reg <= status_reg;
            end else if (reg_addr_i >= sssw_pkg::ADDR_SEL_FIRST
                && reg_addr_i <= sssw_pkg::ADDR_SEL_FIRST + 4'(sssw_pkg::NUM_GPO - 1)) begin
                rdata_reg <= {11'h000, sel_reg[4'(reg_addr_i - sssw_pkg::ADDR_SEL_FIRST)]};
            end else begin
                rdata_reg <= 16'h0000;
            end
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata_o                   = rdata_reg;
    assign spindle_command_echo_status_o = status_reg;
    assign gpo_o                         = gpo_reg;

    // Checks
    property p_mode_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> status_reg[4:0] == $past(mode_select_i);
    endproperty
    a_mode_echo: assert property (p_mode_echo) else $error("mode echo mismatch"); // RQ1

    property p_gear_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> status_reg[6:5] == $past(gear_select_i);
    endproperty
    a_gear_echo: assert property (p_gear_echo) else $error("gear echo mismatch"); // RQ2

    property p_fwd_rot;
        @(posedge clk_i) disable iff (!arst_n_i)
        status_reg[8] |-> $past(start_command_i) && $past(rotating_ccw_i);
    endproperty
    a_fwd_rot: assert property (p_fwd_rot) else $error("forward flag without cause"); // RQ3

    property p_rev_rot;
        @(posedge clk_i) disable iff (!arst_n_i)
        status_reg[9] |-> $past(start_command_i) && $past(rotating_cw_i);
    endproperty
    a_rev_rot: assert property (p_rev_rot) else $error("reverse flag without cause"); // RQ4

    property p_index_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> status_reg[11:10] == {$past(reverse_index_command_i),
                                        $past(forward_index_command_i)};
    endproperty
    a_index_echo: assert property (p_index_echo) else $error("index echo mismatch"); // RQ6

    property p_orient_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(orient_start_command_i) |=> status_reg[12];
    endproperty
    a_orient_echo: assert property (p_orient_echo) else $error("orient echo late"); // RQ7

    property p_wind_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> status_reg[13] == $past(low_winding_select_input_i);
    endproperty
    a_wind_echo: assert property (p_wind_echo) else $error("winding echo mismatch"); // RQ8

    property p_sub_echo;
        @(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> status_reg[14] == $past(sub_motor_select_i);
    endproperty
    a_sub_echo: assert property (p_sub_echo) else $error("sub-motor echo mismatch"); // RQ9

    property p_gpo0_fwd;
        @(posedge clk_i) disable iff (!arst_n_i)
        sel_reg[0] == sssw_pkg::SEL_FWD_ROT && $stable(sel_reg[0])
            |=> gpo_reg[0] == $past(status_reg[8]);
    endproperty
    a_gpo0_fwd: assert property (p_gpo0_fwd) else $error("gpo0 forward route wrong"); // RQ10

    property p_gpo0_rev;
        @(posedge clk_i) disable iff (!arst_n_i)
        sel_reg[0] == sssw_pkg::SEL_REV_ROT && $stable(sel_reg[0])
            |=> gpo_reg[0] == $past(status_reg[9]);
    endproperty
    a_gpo0_rev: assert property (p_gpo0_rev) else $error("gpo0 reverse route wrong"); // RQ11

    property p_gpo0_wind;
        @(posedge clk_i) disable iff (!arst_n_i)
        sel_reg[0] == sssw_pkg::SEL_LOW_WIND && $stable(sel_reg[0])
            |=> gpo_reg[0] == $past(status_reg[13]);
    endproperty
    a_gpo0_wind: assert property (p_gpo0_wind) else $error("gpo0 winding route wrong"); // RQ12

    property p_zero_bits;
        @(posedge clk_i) disable iff (!arst_n_i)
        !status_reg[7] && !status_reg[15];
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unassigned bit set"); // RQ13

    // Positive side of the direction flags, clear side of the orient echo; the checks above cover one side only
    property p_fwd_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        start_command_i && rotating_ccw_i && !rotating_cw_i |=> status_reg[8];
    endproperty
    a_fwd_set: assert property (p_fwd_set) else $error("forward flag missing"); // RQ3

    property p_rev_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        start_command_i && rotating_cw_i && !rotating_ccw_i |=> status_reg[9];
    endproperty
    a_rev_set: assert property (p_rev_set) else $error("reverse flag missing"); // RQ4

    property p_orient_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        !orient_start_command_i |=> !status_reg[12];
    endproperty
    a_orient_clear: assert property (p_orient_clear) else $error("orient echo stuck"); // RQ7

    // Read data stand one cycle only, so a stale word is never taken twice
    property p_rdata_idle;
        @(posedge clk_i) disable iff (!arst_n_i)
        !reg_read_i |=> reg_rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    property p_rdata_status;
        @(posedge clk_i) disable iff (!arst_n_i)
        reg_read_i && reg_addr_i == sssw_pkg::ADDR_STATUS |=> reg_rdata_o == $past(status_reg);
    endproperty
    a_rdata_status: assert property (p_rdata_status) else $error("status read wrong"); // RQ13

    // Every output honours its own code, and only legal codes are ever stored
    for (genvar g = 0; g < sssw_pkg::NUM_GPO; g++) begin : g_sel_chk
        property p_sel_range;
            @(posedge clk_i) disable iff (!arst_n_i)
            sel_reg[g] <= sssw_pkg::SEL_MAX;
        endproperty
        a_sel_range: assert property (p_sel_range) else $error("selection too large"); // RQ10

        property p_gpo_fwd;
            @(posedge clk_i) disable iff (!arst_n_i)
            sel_reg[g] == sssw_pkg::SEL_FWD_ROT |=> gpo_reg[g] == $past(status_reg[8]);
        endproperty
        a_gpo_fwd: assert property (p_gpo_fwd) else $error("forward route wrong"); // RQ10

        property p_gpo_rev;
            @(posedge clk_i) disable iff (!arst_n_i)
            sel_reg[g] == sssw_pkg::SEL_REV_ROT |=> gpo_reg[g] == $past(status_reg[9]);
        endproperty
        a_gpo_rev: assert property (p_gpo_rev) else $error("reverse route wrong"); // RQ11

        property p_gpo_wind;
            @(posedge clk_i) disable iff (!arst_n_i)
            sel_reg[g] == sssw_pkg::SEL_LOW_WIND |=> gpo_reg[g] == $past(status_reg[13]);
        endproperty
        a_gpo_wind: assert property (p_gpo_wind) else $error("winding route wrong"); // RQ12

        property p_gpo_other;
            @(posedge clk_i) disable iff (!arst_n_i)
            sel_reg[g] != sssw_pkg::SEL_FWD_ROT && sel_reg[g] != sssw_pkg::SEL_REV_ROT
                && sel_reg[g] != sssw_pkg::SEL_LOW_WIND |=> !gpo_reg[g];
        endproperty
        a_gpo_other: assert property (p_gpo_other) else $error("stray output"); // RQ10

        property p_wr_lands;
            @(posedge clk_i) disable iff (!arst_n_i)
            reg_write_i && reg_addr_i == sssw_pkg::ADDR_SEL_FIRST + 4'(g)
                && reg_wdata_i <= {11'h000, sssw_pkg::SEL_MAX}
                |=> sel_reg[g] == $past(reg_wdata_i[4:0]);
        endproperty
        a_wr_lands: assert property (p_wr_lands) else $error("legal write lost"); // RQ10

        property p_wr_refused;
            @(posedge clk_i) disable iff (!arst_n_i)
            reg_write_i && reg_addr_i == sssw_pkg::ADDR_SEL_FIRST + 4'(g)
                && reg_wdata_i > {11'h000, sssw_pkg::SEL_MAX}
                |=> $stable(sel_reg[g]);
        endproperty
        a_wr_refused: assert property (p_wr_refused) else $error("refused write taken"); // RQ10
    end

    c_fwd: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(status_reg[8]));
    c_rev: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(status_reg[9]));
    c_gpo: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(gpo_reg[0]));
    c_sel_write: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_write_i && reg_addr_i == sssw_pkg::ADDR_SEL_FIRST);
    c_chatter: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        status_reg[8] ##1 !status_reg[8] ##1 status_reg[8]);
endmodule

`default_nettype wire

// [verif/sssw_nc_reader.sv]
// Purpose: Control unit model that reads status word three
// Assumes: Status word sampled on every rising clock edge
// Notes:   Direction flag chatter is counted, never treated as fault
`timescale 1ns/1ps
`default_nettype none
module sssw_nc_reader (
    // Clock, reset and status
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] status_i,
    // Chatter count
    output logic      [7:0]  flip_count_o
);
    logic [1:0] dir_reg;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_reg      <= 2'h0;
            flip_count_o <= 8'h00;
        end else begin
            dir_reg <= status_i[9:8];
            if (dir_reg != status_i[9:8]) begin
                flip_count_o <= flip_count_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/tb_sssw_status_word.sv]
// Purpose: Self-checking bench for the status word three block
// Assumes: One cycle to status, two to outputs, read data one cycle late
// Notes:   Command inputs packed in one vector, bit 7 is start
`timescale 1ns/1ps
`default_nettype none
module tb_sssw_status_word;
    typedef struct {logic [14:0] c; logic [15:0] s;} sssw_row_t;
    logic        clk_i;
    logic        arst_n_i;
    logic [14:0] cmd;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] status;
    logic [13:0] gpo;
    logic [7:0]  flips;
    logic [7:0]  flips_before;
    int          err_total;
    int          comparisons;
    sssw_row_t   rows [15];
    sssw_status_word sssw_status_word_inst (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .mode_select_i(cmd[4:0]), .gear_select_i(cmd[6:5]),
        .start_command_i(cmd[7]), .rotating_ccw_i(cmd[8]), .rotating_cw_i(cmd[9]),
        .forward_index_command_i(cmd[10]), .reverse_index_command_i(cmd[11]),
        .orient_start_command_i(cmd[12]), .low_winding_select_input_i(cmd[13]),
        .sub_motor_select_i(cmd[14]), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .spindle_command_echo_status_o(status), .gpo_o(gpo));
    sssw_nc_reader sssw_nc_reader_inst (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .status_i(status), .flip_count_o(flips));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d compares", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        {arst_n_i, cmd, addr, wdata, wr, rd} = '0;
        err_total = 0;
        comparisons = 0;
        rows = '{'{15'h0001, 16'h0001}, '{15'h000E, 16'h000E}, '{15'h0010, 16'h0010},
                 '{15'h0020, 16'h0020}, '{15'h0040, 16'h0040}, '{15'h0180, 16'h0100},
                 '{15'h0100, 16'h0000}, '{15'h0280, 16'h0200}, '{15'h0200, 16'h0000},
                 '{15'h0400, 16'h0400}, '{15'h0800, 16'h0800}, '{15'h1000, 16'h1000},
                 '{15'h2000, 16'h2000}, '{15'h4000, 16'h4000}, '{15'h7FFF, 16'h7C7F}};
        settle(8);
        arst_n_i <= 1'b1;
        chk(status | {2'h0, gpo}, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk_i);
            cmd <= rows[i].c;
            settle(2);
            chk(status, rows[i].s);
        end
        rd_chk(4'h0, 16'h7C7F);
        settle(1);
        chk(rdata, 16'h0000);
        wr_reg(4'h1, 16'h0007);
        wr_reg(4'h2, 16'h0008);
        wr_reg(4'h3, 16'h0012);
        wr_reg(4'h4, 16'h0018);
        wr_reg(4'h5, 16'h0027);
        wr_reg(4'hF, 16'hFFFF);
        rd_chk(4'h1, 16'h0007);
        rd_chk(4'h2, 16'h0008);
        rd_chk(4'h3, 16'h0012);
        rd_chk(4'h4, 16'h0000);
        rd_chk(4'h5, 16'h0000);
        rd_chk(4'hF, 16'h0000);
        @(posedge clk_i);
        cmd <= 15'h2180;
        settle(3);
        chk({2'h0, gpo}, 16'h0005);
        @(posedge clk_i);
        cmd <= 15'h0280;
        settle(3);
        chk({2'h0, gpo}, 16'h0002);
        // Low-speed chatter: direction flags toggle, reader counts four changes
        flips_before = flips;
        @(posedge clk_i);
        cmd <= 15'h0180;
        @(posedge clk_i);
        cmd <= 15'h0080;
        @(posedge clk_i);
        cmd <= 15'h0180;
        @(posedge clk_i);
        cmd <= 15'h0280;
        settle(3);
        chk({8'h00, flips - flips_before}, 16'h0004);
        wr_reg(4'h1, 16'h0008);
        settle(2);
        chk({2'h0, gpo}, 16'h0003);
        wr_reg(4'h1, 16'h0012);
        @(posedge clk_i);
        cmd <= 15'h2000;
        settle(3);
        chk({2'h0, gpo}, 16'h0005);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        settle(2);
        chk(status, 16'h0000);
        arst_n_i <= 1'b1;
        rd_chk(4'h1, 16'h0000);
        settle(3);
        chk({2'h0, gpo}, 16'h0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
